// [pkg/ipoc_params.svh]
// Purpose: constants of the image port output configuration block
// Assumes: 8-bit subaddress register port, 32-bit Dword output path
// Notes: offsets are the subaddresses of the register port
//
// Contract
// - horizontal ref pin: gate, extended gate, or rising-edge pulse from either
// - vertical ref pin: gate, input ref, or trigger pulse from either
// - video bytes clipped to 1..254, or 8..247 with range bit set
// - swap field reorders Dword bytes: 0123, 1032, 2301, 3210
// - data qualifier active high, inverted when its polarity bit is 1
// - horizontal and vertical ref pins each invert by own polarity bit
// - each general-purpose flag pin inverts by its own polarity bit
// - arbitration: inhibit, video only, text only, both text first
// - one bit per flag pin is msb of its 3-bit source select
// - almost empty below 16, 8, 4 Dwords, or at zero
// - almost full at least 16, 24, 28, or exactly 32 Dwords
// - output clock phase: default, half cycle, delay, half plus delay
// - gated clock phase, same choices, only when qualifier is gated
// - port enable: off, on, on while tristate pin low, or high
// - flag select 100..111: almost filled, overflow, almost full, almost empty
// - qualifier pin carries qualifier, or qualifier and clock if gated
`ifndef IPOC_PARAMS_SVH
`define IPOC_PARAMS_SVH

`define IPOC_REF_SEL_OFS 8'h84
`define IPOC_FMT_POL_OFS 8'h85
`define IPOC_FIFO_ARB_OFS 8'h86
`define IPOC_EN_PHASE_OFS 8'h87
`define IPOC_STATUS_OFS 8'h8f
`define IPOC_REG_RESET 8'h00
`define IPOC_EN_PHASE_MASK 8'hf3

`define IPOC_ARB_OFF 2'b00
`define IPOC_ARB_VIDEO 2'b01
`define IPOC_ARB_TEXT 2'b10
`define IPOC_ARB_BOTH 2'b11

`define IPOC_EN_OFF 2'b00
`define IPOC_EN_SW 2'b01
`define IPOC_EN_PIN_LOW 2'b10
`define IPOC_EN_PIN_HIGH 2'b11

`define IPOC_SEL_GATE 2'b00
`define IPOC_SEL_ALT 2'b01
`define IPOC_SEL_PULSE 2'b10

`define IPOC_CLIP_LO_WIDE 8'h01
`define IPOC_CLIP_HI_WIDE 8'hfe
`define IPOC_CLIP_LO_NARROW 8'h08
`define IPOC_CLIP_HI_NARROW 8'hf7

`define IPOC_AE_LVL_0 6'd16
`define IPOC_AE_LVL_1 6'd8
`define IPOC_AE_LVL_2 6'd4
`define IPOC_AF_LVL_0 6'd16
`define IPOC_AF_LVL_1 6'd24
`define IPOC_AF_LVL_2 6'd28
`define IPOC_AF_LVL_3 6'd32

`define IPOC_CLK_DELAY_NS 3

`endif

// [pkg/ipoc_pkg.sv]
// Purpose: types of the image port output configuration block
// Assumes: field order follows the register bit order, msb first
// Notes: none
package ipoc_pkg;

  typedef struct packed {
    logic [1:0] flag0_sel_lo;
    logic [1:0] flag1_sel_lo;
    logic [1:0] vert_ref_select;
    logic [1:0] horiz_ref_select;
  } ipoc_refsel_type;

  typedef struct packed {
    logic [1:0] byte_swap_field;
    logic range_limit_bit;
    logic flag0_polarity;
    logic flag1_polarity;
    logic vert_ref_polarity;
    logic horiz_ref_polarity;
    logic qualifier_polarity;
  } ipoc_fmt_type;

  typedef struct packed {
    logic [1:0] text_video_arbitration;
    logic flag0_select_msb;
    logic flag1_select_msb;
    logic [1:0] almost_full_level;
    logic [1:0] almost_empty_level;
  } ipoc_arb_type;

  typedef struct packed {
    logic [1:0] gated_clock_phase;
    logic [1:0] out_clock_phase;
    logic [1:0] unused;
    logic [1:0] port_output_enable;
  } ipoc_phase_type;

  typedef struct packed {
    logic almost_filled;
    logic overflow;
    logic almost_full;
    logic almost_empty;
  } ipoc_flags_type;

endpackage

// [rtl/ipoc_port.sv]
// Purpose: image port output configuration, output FIFO and pin drive
// Assumes: scaler side on ref_clk, port side on port_clk
// Notes: approx 3 ns delays are pad cells steered by the delay selects
`timescale 1ns/1ns
`include "ipoc_params.svh"

module ipoc_fifo
  import ipoc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic [$clog2(DEPTH):0] wr_level,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] rgray_s1_q, rgray_s2_q, wgray_s1_q, wgray_s2_q;
  logic [AW:0] rbin_w;
  logic push, pop;

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rbin_w = gray2bin(rgray_s2_q);
  assign wr_level = wbin_q - rbin_w;
  assign in_ready = (wr_level != (AW+1)'(DEPTH));
  assign out_valid = (rgray_q != wgray_s2_q);
  assign out_data = mem[rbin_q[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_q <= '0;
      wgray_q <= '0;
    end else if (push) begin
      wbin_q <= wbin_q + 1'b1;
      wgray_q <= (wbin_q + 1'b1) ^ ((wbin_q + 1'b1) >> 1);
    end
  end

  // gray pointers cross, two flops each way
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      rgray_s1_q <= '0;
      rgray_s2_q <= '0;
    end else begin
      rgray_s1_q <= rgray_q;
      rgray_s2_q <= rgray_s1_q;
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_q <= '0;
      rgray_q <= '0;
    end else if (pop) begin
      rbin_q <= rbin_q + 1'b1;
      rgray_q <= (rbin_q + 1'b1) ^ ((rbin_q + 1'b1) >> 1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      wgray_s1_q <= '0;
      wgray_s2_q <= '0;
    end else begin
      wgray_s1_q <= wgray_q;
      wgray_s2_q <= wgray_s1_q;
    end
  end
endmodule

module ipoc_port
  import ipoc_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic port_clk,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic qualifier_gating_select,
  input wire logic vid_valid,
  input wire logic [31:0] vid_data,
  output logic vid_ready,
  input wire logic txt_valid,
  input wire logic [31:0] txt_data,
  output logic txt_ready,
  input wire logic h_gate,
  input wire logic h_ref_in,
  input wire logic in_window,
  input wire logic v_gate,
  input wire logic v_ref_in,
  input wire logic field_id,
  input wire logic task_flag,
  input wire logic sliced_flag,
  input wire logic port_tristate_pin,
  output logic [31:0] port_data_o,
  output logic port_clock_o,
  output logic port_clock_delay_sel,
  output logic data_qualifier_pin_o,
  output logic qualifier_delay_sel,
  output logic horiz_ref_pin_o,
  output logic vert_ref_pin_o,
  output logic flag_pin_0_o,
  output logic flag_pin_1_o,
  output logic port_oe
);
  ipoc_refsel_type refsel_q;
  ipoc_fmt_type fmt_q;
  ipoc_arb_type arb_q;
  ipoc_phase_type phase_q;
  ipoc_flags_type flags;
  logic [1:0] rst_q, prst_q, tri_q, pen_q;
  logic rst_n, prst_n;
  logic [5:0] level, ae_lvl, af_lvl;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [31:0] fifo_in_data, fifo_out_data, src_data;
  logic use_txt, use_vid, ovf_q, port_en;
  logic h_gate_q, h_ext_q, v_gate_q, v_ref_q, h_ext;
  logic horiz_raw_q, vert_raw_q, dq_q;
  logic [1:0] flag_q;
  logic [7:0] clip_lo, clip_hi;
  logic [31:0] pdata_q;

  // reset release, one copy per domain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge port_clk or negedge arst_n) begin
    if (!arst_n) begin
      prst_q <= 2'b00;
    end else begin
      prst_q <= {prst_q[0], 1'b1};
    end
  end
  assign prst_n = prst_q[1];

  // register writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refsel_q <= `IPOC_REG_RESET;
      fmt_q <= `IPOC_REG_RESET;
      arb_q <= `IPOC_REG_RESET;
      phase_q <= `IPOC_REG_RESET;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `IPOC_REF_SEL_OFS: refsel_q <= reg_wdata;
        `IPOC_FMT_POL_OFS: fmt_q <= reg_wdata;
        `IPOC_FIFO_ARB_OFS: arb_q <= reg_wdata;
        `IPOC_EN_PHASE_OFS: phase_q <= reg_wdata & `IPOC_EN_PHASE_MASK;
        default: ;
      endcase
    end
  end

  // register reads, unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `IPOC_REF_SEL_OFS: reg_rdata <= refsel_q;
        `IPOC_FMT_POL_OFS: reg_rdata <= fmt_q;
        `IPOC_FIFO_ARB_OFS: reg_rdata <= arb_q;
        `IPOC_EN_PHASE_OFS: reg_rdata <= phase_q;
        `IPOC_STATUS_OFS: reg_rdata <= {ovf_q, flags.almost_full, level};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // source arbitration; a deselected source is drained and dropped
  always_comb begin
    use_txt = 1'b0;
    use_vid = 1'b0;
    txt_ready = 1'b1;
    vid_ready = 1'b1;
    case (arb_q.text_video_arbitration)
      `IPOC_ARB_VIDEO: begin
        use_vid = vid_valid;
        vid_ready = fifo_in_ready;
      end
      `IPOC_ARB_TEXT: begin
        use_txt = txt_valid;
        txt_ready = fifo_in_ready;
      end
      `IPOC_ARB_BOTH: begin
        use_txt = txt_valid;
        use_vid = vid_valid && !txt_valid;
        txt_ready = fifo_in_ready;
        vid_ready = fifo_in_ready && !txt_valid;
      end
      default: ;
    endcase
  end
  assign fifo_in_valid = use_txt || use_vid;

  assign clip_lo = fmt_q.range_limit_bit ? `IPOC_CLIP_LO_NARROW
                                         : `IPOC_CLIP_LO_WIDE;
  assign clip_hi = fmt_q.range_limit_bit ? `IPOC_CLIP_HI_NARROW
                                         : `IPOC_CLIP_HI_WIDE;

  // text passes unclipped, only video samples are range limited
  for (genvar k = 0; k < 4; k++) begin : g_byte
    logic [7:0] vb;
    assign vb = vid_data[8*k +: 8];
    assign src_data[8*k +: 8] = use_txt ? txt_data[8*k +: 8] :
      (vb < clip_lo) ? clip_lo : (vb > clip_hi) ? clip_hi : vb;
    assign fifo_in_data[8*k +: 8] =
      src_data[8*(k ^ int'(fmt_q.byte_swap_field)) +: 8];
  end

  ipoc_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .wr_clk(ref_clk),
    .wr_rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .wr_level(level),
    .rd_clk(port_clk),
    .rd_rst_n(prst_n),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  always_comb begin
    case (arb_q.almost_empty_level)
      2'd0: ae_lvl = `IPOC_AE_LVL_0;
      2'd1: ae_lvl = `IPOC_AE_LVL_1;
      2'd2: ae_lvl = `IPOC_AE_LVL_2;
      default: ae_lvl = 6'd1;
    endcase
    case (arb_q.almost_full_level)
      2'd0: af_lvl = `IPOC_AF_LVL_0;
      2'd1: af_lvl = `IPOC_AF_LVL_1;
      2'd2: af_lvl = `IPOC_AF_LVL_2;
      default: af_lvl = `IPOC_AF_LVL_3;
    endcase
  end
  assign flags.almost_empty = (level < ae_lvl);
  assign flags.almost_full = (level >= af_lvl);
  assign flags.almost_filled = !flags.almost_empty && !flags.almost_full;
  assign flags.overflow = ovf_q;

  // sticky overflow: set wins over the clear on a status read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (fifo_in_valid && !fifo_in_ready) begin
      ovf_q <= 1'b1;
    end else if (reg_rd_en && reg_addr == `IPOC_STATUS_OFS) begin
      ovf_q <= 1'b0;
    end
  end

  // reference pins
  assign h_ext = in_window ? h_gate : h_ref_in;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_gate_q <= 1'b0;
      h_ext_q <= 1'b0;
      horiz_raw_q <= 1'b0;
    end else begin
      h_gate_q <= h_gate;
      h_ext_q <= h_ext;
      case (refsel_q.horiz_ref_select)
        `IPOC_SEL_GATE: horiz_raw_q <= h_gate;
        `IPOC_SEL_ALT: horiz_raw_q <= h_ext;
        `IPOC_SEL_PULSE: horiz_raw_q <= h_gate && !h_gate_q;
        default: horiz_raw_q <= h_ext && !h_ext_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      v_gate_q <= 1'b0;
      v_ref_q <= 1'b0;
      vert_raw_q <= 1'b0;
    end else begin
      v_gate_q <= v_gate;
      v_ref_q <= v_ref_in;
      case (refsel_q.vert_ref_select)
        `IPOC_SEL_GATE: vert_raw_q <= v_gate;
        `IPOC_SEL_ALT: vert_raw_q <= v_ref_in;
        `IPOC_SEL_PULSE: vert_raw_q <= v_gate && !v_gate_q;
        default: vert_raw_q <= v_ref_in && !v_ref_q;
      endcase
    end
  end
  assign horiz_ref_pin_o = horiz_raw_q ^ fmt_q.horiz_ref_polarity;
  assign vert_ref_pin_o = vert_raw_q ^ fmt_q.vert_ref_polarity;

  // general-purpose flag pins
  for (genvar f = 0; f < 2; f++) begin : g_flag
    logic [2:0] sel;
    logic src;
    logic pol;
    assign sel = (f == 0) ?
      {arb_q.flag0_select_msb, refsel_q.flag0_sel_lo} :
      {arb_q.flag1_select_msb, refsel_q.flag1_sel_lo};
    assign pol = (f == 0) ? fmt_q.flag0_polarity : fmt_q.flag1_polarity;
    always_comb begin
      case (sel)
        3'd0: src = field_id;
        3'd1: src = task_flag;
        3'd2: src = sliced_flag;
        3'd4: src = flags.almost_filled;
        3'd5: src = flags.overflow;
        3'd6: src = flags.almost_full;
        3'd7: src = flags.almost_empty;
        default: src = 1'b0;
      endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_q[f] <= 1'b0;
      end else begin
        flag_q[f] <= src ^ pol;
      end
    end
  end
  assign flag_pin_0_o = flag_q[0];
  assign flag_pin_1_o = flag_q[1];

  // port enable, tristate pin synchronised first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tri_q <= 2'b00;
    end else begin
      tri_q <= {tri_q[0], port_tristate_pin};
    end
  end

  always_comb begin
    case (phase_q.port_output_enable)
      `IPOC_EN_SW: port_en = 1'b1;
      `IPOC_EN_PIN_LOW: port_en = !tri_q[1];
      `IPOC_EN_PIN_HIGH: port_en = tri_q[1];
      default: port_en = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_oe <= 1'b0;
    end else begin
      port_oe <= port_en;
    end
  end

  // port side: drain only while the port drives, so the FIFO backs up
  always_ff @(posedge port_clk or negedge prst_n) begin
    if (!prst_n) begin
      pen_q <= 2'b00;
    end else begin
      pen_q <= {pen_q[0], port_oe};
    end
  end
  assign fifo_pop = fifo_out_valid && pen_q[1];

  always_ff @(posedge port_clk or negedge prst_n) begin
    if (!prst_n) begin
      pdata_q <= 32'h0000_0000;
      dq_q <= 1'b0;
    end else begin
      dq_q <= fifo_pop;
      if (fifo_pop) begin
        pdata_q <= fifo_out_data;
      end
    end
  end
  assign port_data_o = pdata_q;

  // half-cycle shift is a clock inversion; the delay is left to the pad
  assign port_clock_o = port_clk ^ phase_q.out_clock_phase[0];
  assign port_clock_delay_sel = phase_q.out_clock_phase[1];
  assign qualifier_delay_sel = qualifier_gating_select &&
    phase_q.gated_clock_phase[1];
  assign data_qualifier_pin_o = fmt_q.qualifier_polarity ^
    (qualifier_gating_select ?
     (dq_q && (port_clk ^ phase_q.gated_clock_phase[0])) : dq_q);

  clip_lo_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    use_vid && fmt_q.range_limit_bit |-> src_data[7:0] >= 8'h08
    && src_data[31:24] <= 8'hf7)
    else $error("video byte outside narrow range");

  swap_full_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    use_txt && fmt_q.byte_swap_field == 2'b11 |->
    fifo_in_data[7:0] == txt_data[31:24])
    else $error("full byte swap wrong");

  arb_off_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    arb_q.text_video_arbitration == 2'b00 |-> !fifo_in_valid)
    else $error("data written while inhibited");

  text_first_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    arb_q.text_video_arbitration == 2'b11 && txt_valid && vid_valid
    |-> !vid_ready && use_txt)
    else $error("video not held behind text");

  empty_lvl_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    arb_q.almost_empty_level == 2'b11 |-> flags.almost_empty == (level == 0))
    else $error("almost empty wrong at zero level");

  full_lvl_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    arb_q.almost_full_level == 2'b01 |-> flags.almost_full == (level >= 24))
    else $error("almost full wrong at 24");

  sequence h_rise_s;
    refsel_q.horiz_ref_select == 2'b10 && h_gate && !h_gate_q;
  endsequence
  h_pulse_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    h_rise_s ##1 $stable(refsel_q) |-> horiz_raw_q ##1
    (!horiz_raw_q || !$stable(refsel_q)))
    else $error("horizontal pulse not one cycle");

  oe_off_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    phase_q.port_output_enable == 2'b00 [*2] |-> !port_oe)
    else $error("port driven while disabled");

  ovf_set_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    fifo_in_valid && !fifo_in_ready |=> ovf_q)
    else $error("overflow not caught");
endmodule

// [tb/ipoc_capture_model.sv]
// Purpose: capture controller model at the image output port
// Assumes: ungated qualifier, data taken on the rising port clock
// Notes: received Dwords queue up for the bench to pop
`timescale 1ns/1ns
module ipoc_capture_model (
  input wire logic port_clk,
  input wire logic port_oe,
  input wire logic qual_pol,
  input wire logic data_qualifier_pin_o,
  input wire logic [31:0] port_data_o
);
  logic [31:0] rx_q[$];
  // polarity undone here, so a wrong inversion shows as lost or extra words
  always @(posedge port_clk) begin
    if (port_oe === 1'b1 &&
        (data_qualifier_pin_o ^ qual_pol) === 1'b1) begin
      rx_q.push_back(port_data_o);
    end
  end
endmodule

// [tb/ipoc_port_tb.sv]
// Purpose: self-checking bench of the image port output block
// Assumes: port clock free running at 160 ns, core clock 8 ns
// Notes: random stimulus from a fixed seed plus corner bytes
`timescale 1ns/1ns
`include "ipoc_params.svh"
module image_port_output_config_bench
  import ipoc_pkg::*;
;
  logic ref_clk = 1'b0, port_clk = 1'b0, arst_n = 1'b0;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, qual_pol = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [31:0] vid_data = 32'h0, txt_data = 32'h0, port_data_o;
  logic vid_valid = 1'b0, txt_valid = 1'b0, vid_ready, txt_ready;
  logic h_gate = 1'b0, h_ref_in = 1'b0, in_window = 1'b0;
  logic v_gate = 1'b0, v_ref_in = 1'b0, field_id = 1'b0;
  logic task_flag = 1'b0, sliced_flag = 1'b0, port_tristate_pin = 1'b0;
  logic qualifier_gating_select = 1'b0;
  logic port_clock_o, port_clock_delay_sel, data_qualifier_pin_o;
  logic qualifier_delay_sel, horiz_ref_pin_o, vert_ref_pin_o;
  logic flag_pin_0_o, flag_pin_1_o, port_oe;
  int failures = 0, total_checks = 0;

  ipoc_port #(.DEPTH(32)) dut (.ref_clk, .arst_n, .port_clk, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .qualifier_gating_select,
    .vid_valid, .vid_data, .vid_ready, .txt_valid, .txt_data, .txt_ready,
    .h_gate, .h_ref_in, .in_window, .v_gate, .v_ref_in, .field_id,
    .task_flag, .sliced_flag, .port_tristate_pin, .port_data_o,
    .port_clock_o, .port_clock_delay_sel, .data_qualifier_pin_o,
    .qualifier_delay_sel, .horiz_ref_pin_o, .vert_ref_pin_o, .flag_pin_0_o,
    .flag_pin_1_o, .port_oe);
  ipoc_capture_model cap (.port_clk, .port_oe, .qual_pol,
    .data_qualifier_pin_o, .port_data_o);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #3;
    forever #80 port_clk = ~port_clk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(s, e, reg_rdata);
  endtask
  task automatic snd(input bit t, input logic [31:0] w);
    bit ok;
    int i;
    ok = 1'b0;
    @(posedge ref_clk);
    if (t) begin
      txt_valid <= 1'b1;
      txt_data <= w;
    end else begin
      vid_valid <= 1'b1;
      vid_data <= w;
    end
    for (i = 0; i < 300 && !ok; i++) begin
      @(negedge ref_clk);
      ok = t ? (txt_ready === 1'b1) : (vid_ready === 1'b1);
      @(posedge ref_clk);
    end
    if (t) txt_valid <= 1'b0;
    else vid_valid <= 1'b0;
    if (!ok) begin
      chk("stream ready", 1, 0);
      end_sim();
    end
  endtask
  task automatic get(output logic [31:0] w);
    int i;
    for (i = 0; i < 400 && cap.rx_q.size() == 0; i++) @(posedge ref_clk);
    if (cap.rx_q.size() == 0) begin
      chk("rx word", 1, 0);
      end_sim();
    end else begin
      w = cap.rx_q.pop_front();
    end
  endtask
  // byte k of the result is source byte k xor swap; clip only video
  function automatic logic [31:0] xf(input logic [31:0] w,
    input logic [1:0] sw, input logic rl, input bit cl);
    logic [7:0] b, lo, hi;
    logic [31:0] r;
    lo = rl ? `IPOC_CLIP_LO_NARROW : `IPOC_CLIP_LO_WIDE;
    hi = rl ? `IPOC_CLIP_HI_NARROW : `IPOC_CLIP_HI_WIDE;
    for (int k = 0; k < 4; k++) begin
      b = w[8*(k^sw) +: 8];
      if (cl && b < lo) b = lo;
      if (cl && b > hi) b = hi;
      r[8*k +: 8] = b;
    end
    return r;
  endfunction
  function automatic bit aef(input int n, input int m);
    return m == 0 ? n < 16 : m == 1 ? n < 8 : m == 2 ? n < 4 : n == 0;
  endfunction
  function automatic bit aff(input int n, input int m);
    return m == 0 ? n >= 16 : m == 1 ? n >= 24 : m == 2 ? n >= 28 : n == 32;
  endfunction
  // fifo empty here: almost empty high, other fifo flags low
  function automatic logic fs(input logic [2:0] s, input logic [2:0] f);
    return s == 0 ? f[2] : s == 1 ? f[1] : s == 2 ? f[0] : s == 7;
  endfunction

  initial begin
    logic [31:0] w, w2, g, exp_q[$];
    logic [7:0] d;
    int i, n, m, t, h;
    void'($urandom(32'h17fc));
    repeat (16) @(posedge ref_clk);
    // slow port clock needs three edges inside reset as well
    repeat (3) @(posedge port_clk);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 4; i++) rc("reset value", 8'(8'h84 + i), 8'h00);
    rc("status reset", 8'h8f, 8'h00);
    wr(8'h90, 8'hff);
    rc("unmapped", 8'h90, 8'h00);
    wr(8'h87, 8'h0c);
    rc("reserved bits", 8'h87, 8'h00);
    for (i = 0; i < 16; i++) begin
      t = $urandom % 2;
      wr(8'h87, {i[3:0], 4'h1});
      qualifier_gating_select <= t[0];
      @(posedge port_clk);
      #2;
      chk("clock phase", !i[0], port_clock_o);
      chk("clock delay", i[1], port_clock_delay_sel);
      chk("gated delay", i[3] & t[0], qualifier_delay_sel);
      chk("idle qualifier", 0, data_qualifier_pin_o);
      rc("phase readback", 8'h87, {i[3:0], 4'h1});
    end
    qualifier_gating_select <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wr(8'h87, {6'h00, i[1:0]});
      port_tristate_pin <= i[2];
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      h = i[1:0] == 1 || (i[1:0] == 2 && !i[2]) || (i[1:0] == 3 && i[2]);
      chk("port enable", h, port_oe);
    end
    wr(8'h87, 8'h00);
    $display("test registers and enable done");
    for (i = 0; i < 40; i++) begin
      w = $urandom;
      wr(8'h84, {4'h0, 1'b0, w[0], 1'b0, w[1]});
      wr(8'h85, {5'h00, w[2], w[3], 1'b0});
      {h_gate, h_ref_in, in_window, v_gate, v_ref_in} <= w[8:4];
      @(posedge ref_clk);
      @(negedge ref_clk);
      h = (w[1] ? (w[6] ? w[8] : w[7]) : w[8]) ^ w[3];
      chk("horiz ref", h, horiz_ref_pin_o);
      h = (w[0] ? w[4] : w[5]) ^ w[2];
      chk("vert ref", h, vert_ref_pin_o);
    end
    wr(8'h85, 8'h00);
    for (m = 2; m < 4; m++) begin
      wr(8'h84, {4'h0, m[1:0], m[1:0]});
      {h_gate, h_ref_in, in_window, v_gate, v_ref_in} <= 5'h00;
      repeat (3) @(posedge ref_clk);
      {h_gate, h_ref_in, in_window, v_gate, v_ref_in} <= 5'h1b;
      n = 0;
      t = 0;
      repeat (5) begin
        @(negedge ref_clk);
        n += (horiz_ref_pin_o === 1'b1);
        t += (vert_ref_pin_o === 1'b1);
      end
      chk("horiz pulse", 1, n);
      chk("vert pulse", 1, t);
    end
    $display("test reference pins done");
    for (i = 0; i < 24; i++) begin
      w = $urandom;
      wr(8'h84, {w[1:0], w[4:3], 4'h0});
      wr(8'h86, {2'b00, w[2], w[5], 4'h0});
      wr(8'h85, {3'b000, w[6], w[7], 3'b000});
      {field_id, task_flag, sliced_flag} <= w[10:8];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      h = fs(w[2:0], w[10:8]) ^ w[6];
      n = fs(w[5:3], w[10:8]) ^ w[7];
      chk("flag 0", h, flag_pin_0_o);
      chk("flag 1", n, flag_pin_1_o);
    end
    wr(8'h85, 8'h00);
    wr(8'h84, 8'he0);
    wr(8'h86, 8'h70);
    for (n = 0; n <= 32; n++) begin
      if (n > 0) begin
        w = (n == 1) ? 32'h00ff07f8 : $urandom;
        snd(0, w);
        exp_q.push_back(xf(w, 2'b00, 1'b0, 1));
      end
      for (m = 0; m < 4; m++) begin
        wr(8'h86, {2'b01, 2'b11, m[1:0], m[1:0]});
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("almost empty", aef(n, m), flag_pin_0_o);
        chk("almost full", aff(n, m), flag_pin_1_o);
      end
      rc("fill level", 8'h8f, {1'b0, aff(n, 3), n[5:0]});
    end
    @(negedge ref_clk);
    chk("full refuses", 0, vid_ready);
    @(posedge ref_clk);
    vid_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    vid_valid <= 1'b0;
    wr(8'h84, 8'h60);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("overflow flag", 1, flag_pin_0_o);
    rc("overflow set", 8'h8f, 8'he0);
    rc("overflow clear", 8'h8f, 8'h60);
    wr(8'h87, 8'h01);
    for (n = 0; n < 32; n++) begin
      get(g);
      chk("drained word", exp_q.pop_front(), g);
    end
    repeat (50) @(posedge ref_clk);
    rc("drained level", 8'h8f, 8'h00);
    $display("test fifo levels done");
    for (i = 0; i < 24; i++) begin
      w = (i < 4) ? 32'hf807ff00 : $urandom;
      w2 = $urandom;
      m = (i < 4) ? 1 : $urandom % 4;
      t = (i < 4) ? 0 : $urandom % 2;
      d = (i < 4) ? {i[1:0], i[0], 5'h00} : 8'($urandom);
      wr(8'h85, {d[7:5], 4'h0, d[0]});
      qual_pol <= d[0];
      wr(8'h86, {m[1:0], 6'h00});
      repeat (60) @(posedge ref_clk);
      cap.rx_q.delete();
      if (m == 3) begin
        fork
          snd(1, w2);
          snd(0, w);
        join
        get(g);
        chk("text first", xf(w2, d[7:6], d[5], 0), g);
        get(g);
        chk("video after", xf(w, d[7:6], d[5], 1), g);
      end else begin
        snd(t[0], t ? w2 : w);
        if (m == 0 || (m == 1 && t == 1) || (m == 2 && t == 0)) begin
          repeat (200) @(posedge ref_clk);
          chk("dropped", 0, cap.rx_q.size());
        end else begin
          get(g);
          w = xf(t ? w2 : w, d[7:6], d[5], !t);
          chk("stream word", w, g);
        end
      end
    end
    $display("test streams done");
    end_sim();
  end
endmodule
